// File: hdl/serial_cfg_regs.svh
// Overview of operation
// - a frame starts on the first sampled strobe low; strobe high means idle
// - every frame is 16 bits: 4 address bits then 12 data bits
// - addresses 0 to 5 select registers; 6 to 15 are reserved
// - the operating state register resets to 0x7FF
// - state bit 0 picks demux ratio, 1 means two ports, default 1
// - state bit 1 low enables the delay trim, default 1
// - state bit 2 low turns test pattern on, default 1
// - state bit 6 low gives full output rate in single port, default 1
// - state bit 7 picks alignment edge, 0 rising 1 falling, default 1
// - state bit 8 low forwards pulse to parity pins; high realigns internals
// - changing the test mode bit never disturbs the synchronisation state
// - gain trim is a 10-bit field, default 0x200
// - offset trim is a 10-bit field, default 0x200
// - delay trim holds coarse bits 9:8 and fine bits 7:0
// - coarse default 0x02, fine default 0x00
// - spare register holds a 5-bit field, default 0x1F
// - pattern select holds a low test type field, default 0x03
// - strobe and data sampled on rising link clock, msb first
// - write only after 16 straight low samples; early high aborts
// - port reset low with strobe low loads every default
// - data bits above a field are dropped but still shifted
`ifndef SERIAL_CFG_REGS_SVH
`define SERIAL_CFG_REGS_SVH
`define FRAME_BITS 16
`define ADDR_BITS 4
`define DATA_BITS 12
`define LAST_BIT_COUNT 4'hf
`define OPERATING_STATE_ADDR 4'h0
`define GAIN_TRIM_ADDR 4'h1
`define OFFSET_TRIM_ADDR 4'h2
`define APERTURE_DELAY_TRIM_ADDR 4'h3
`define SPARE_RESERVED_ADDR 4'h4
`define PATTERN_SELECT_ADDR 4'h5
`define ST_DEMUX_BIT 0
`define ST_DELAY_EN_BIT 1
`define ST_PATTERN_BIT 2
`define ST_RATE_BIT 6
`define ST_EDGE_BIT 7
`define ST_PULSE_BIT 8
`define OPERATING_STATE_RESET 12'h7ff
`define GAIN_TRIM_RESET 10'h200
`define OFFSET_TRIM_RESET 10'h200
`define DELAY_COARSE_RESET 2'h2
`define DELAY_FINE_RESET 8'h00
`define SPARE_FIELD_RESET 5'h1f
`define PATTERN_TYPE_RESET 12'h003
`endif

// File: hdl/cfg_pkg.sv
package cfg_pkg;
   // one-hot frame tracker states
   typedef enum logic [2:0] {
      FRAME_IDLE = 3'h1,
      FRAME_SHIFT = 3'h2,
      FRAME_DONE = 3'h4
   } frame_state_e;
   typedef logic [3:0] cfg_addr_t;
   typedef logic [11:0] cfg_data_t;
endpackage

// File: hdl/cfg_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
// link samples in, decoded writes out
interface cfg_frame_if;
   logic ce;
   logic tick;
   logic sld_n;
   logic mosi;
   logic wr_pulse;
   cfg_pkg::cfg_addr_t wr_addr;
   cfg_pkg::cfg_data_t wr_data;
   modport source (output ce, output tick, output sld_n, output mosi,
      input wr_pulse, input wr_addr, input wr_data);
   modport sink (input ce, input tick, input sld_n, input mosi,
      output wr_pulse, output wr_addr, output wr_data);
endinterface
`default_nettype wire

// File: hdl/frame_deserializer.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_regs.svh"
module frame_deserializer (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // link samples and decoded writes
   cfg_frame_if.sink frame
);
   cfg_pkg::frame_state_e state_reg;
   logic [3:0] count_reg;
   logic [14:0] shift_reg;
   logic [15:0] word_next;

   // new bit joins at the bottom, so the first bit ends up as msb
   assign word_next = {shift_reg, frame.mosi};

   // frame tracker: abort on early high, ignore extra low cycles
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= cfg_pkg::FRAME_IDLE;
         count_reg <= 4'h0;
         shift_reg <= 15'h0000;
         frame.wr_pulse <= 1'b0;
         frame.wr_addr <= 4'h0;
         frame.wr_data <= 12'h000;
      end else if (frame.ce) begin
         frame.wr_pulse <= 1'b0;
         if (frame.tick) begin
            case (state_reg)
               cfg_pkg::FRAME_IDLE: begin
                  if (!frame.sld_n) begin
                     shift_reg <= word_next[14:0];
                     count_reg <= 4'h1;
                     state_reg <= cfg_pkg::FRAME_SHIFT;
                  end
               end
               cfg_pkg::FRAME_SHIFT: begin
                  if (frame.sld_n) begin
                     count_reg <= 4'h0;
                     state_reg <= cfg_pkg::FRAME_IDLE;
                  end else if (count_reg == `LAST_BIT_COUNT) begin
                     frame.wr_pulse <= 1'b1;
                     frame.wr_addr <= word_next[15:12];
                     frame.wr_data <= word_next[11:0];
                     count_reg <= 4'h0;
                     state_reg <= cfg_pkg::FRAME_DONE;
                  end else begin
                     shift_reg <= word_next[14:0];
                     count_reg <= 4'(count_reg + 4'h1);
                  end
               end
               cfg_pkg::FRAME_DONE: begin
                  if (frame.sld_n) begin
                     state_reg <= cfg_pkg::FRAME_IDLE;
                  end
               end
               default: begin
                  state_reg <= cfg_pkg::FRAME_IDLE;
                  count_reg <= 4'h0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/config_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_regs.svh"
module config_serial_port #(
   parameter int PATTERN_W = 4
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // serial configuration pins
   input wire logic sck_in,
   input wire logic sld_n_in,
   input wire logic mosi_in,
   input wire logic cfg_reset_n_in,
   // external alignment pulse
   input wire logic align_pulse_in,
   // operating state fields
   output logic demux_ratio_select_out,
   output logic delay_trim_enable_n_out,
   output logic pattern_mode_n_out,
   output logic fast_output_rate_n_out,
   output logic alignment_edge_select_out,
   output logic pulse_mode_select_n_out,
   // trim fields
   output logic [9:0] amplitude_trim_out,
   output logic [9:0] offset_trim_out,
   output logic [1:0] delay_coarse_out,
   output logic [7:0] delay_fine_out,
   output logic [4:0] spare_field_out,
   output logic [PATTERN_W-1:0] pattern_type_out,
   // alignment results
   output logic [1:0] parity_output_pair_out,
   output logic realign_out,
   output logic [1:0] sync_phase_out
);
   localparam logic [PATTERN_W-1:0] PATTERN_RESET =
      PATTERN_W'(`PATTERN_TYPE_RESET);
   // full state word, so each field default is picked by its bit position
   localparam logic [11:0] STATE_RESET = `OPERATING_STATE_RESET;

   // synchroniser stages; stage one feeds stage two only
   logic sck_s1_reg, sck_s2_reg, sck_d_reg;
   logic sld_s1_reg, sld_s2_reg, sld_d_reg;
   logic mosi_s1_reg, mosi_s2_reg, mosi_d_reg;
   logic crst_s1_reg, crst_s2_reg;
   logic align_s1_reg, align_s2_reg, align_d_reg;

   // register fields
   logic demux_reg, delay_en_n_reg, pattern_n_reg;
   logic rate_n_reg, edge_reg, pulse_n_reg;
   logic [9:0] gain_reg;
   logic [9:0] offset_reg;
   logic [1:0] coarse_reg;
   logic [7:0] fine_reg;
   logic [4:0] spare_reg;
   logic [PATTERN_W-1:0] pattern_reg;

   // alignment path
   logic [1:0] parity_reg;
   logic realign_reg;
   logic [1:0] phase_reg;
   logic align_rise, align_fall, align_hit;

   logic link_tick;
   logic defaults_load;

   cfg_frame_if frame ();

   // bring the link pins and the port reset into the clk_in domain
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sck_d_reg <= 1'b0;
         sld_s1_reg <= 1'b1;
         sld_s2_reg <= 1'b1;
         sld_d_reg <= 1'b1;
         mosi_s1_reg <= 1'b0;
         mosi_s2_reg <= 1'b0;
         mosi_d_reg <= 1'b0;
         crst_s1_reg <= 1'b1;
         crst_s2_reg <= 1'b1;
      end else if (ce_in) begin
         sck_s1_reg <= sck_in;
         sck_s2_reg <= sck_s1_reg;
         sck_d_reg <= sck_s2_reg;
         sld_s1_reg <= sld_n_in;
         sld_s2_reg <= sld_s1_reg;
         sld_d_reg <= sld_s2_reg;
         mosi_s1_reg <= mosi_in;
         mosi_s2_reg <= mosi_s1_reg;
         mosi_d_reg <= mosi_s2_reg;
         crst_s1_reg <= cfg_reset_n_in;
         crst_s2_reg <= crst_s1_reg;
      end
   end

   // rising link clock; data taken one stage older, from before the edge,
   // so the link needs data stable one clk_in period ahead of sck rise
   assign link_tick = sck_s2_reg & ~sck_d_reg;
   assign defaults_load = ~crst_s2_reg & ~sld_s2_reg;

   // hand samples to the frame tracker
   assign frame.ce = ce_in;
   assign frame.tick = link_tick;
   assign frame.sld_n = sld_d_reg;
   assign frame.mosi = mosi_d_reg;

   frame_deserializer u_deser (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .frame(frame.sink)
   );

   // register bank; default load outranks a write in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         demux_reg <= STATE_RESET[`ST_DEMUX_BIT];
         delay_en_n_reg <= STATE_RESET[`ST_DELAY_EN_BIT];
         pattern_n_reg <= STATE_RESET[`ST_PATTERN_BIT];
         rate_n_reg <= STATE_RESET[`ST_RATE_BIT];
         edge_reg <= STATE_RESET[`ST_EDGE_BIT];
         pulse_n_reg <= STATE_RESET[`ST_PULSE_BIT];
         gain_reg <= `GAIN_TRIM_RESET;
         offset_reg <= `OFFSET_TRIM_RESET;
         coarse_reg <= `DELAY_COARSE_RESET;
         fine_reg <= `DELAY_FINE_RESET;
         spare_reg <= `SPARE_FIELD_RESET;
         pattern_reg <= PATTERN_RESET;
      end else if (ce_in) begin
         if (defaults_load) begin
            demux_reg <= STATE_RESET[`ST_DEMUX_BIT];
            delay_en_n_reg <= STATE_RESET[`ST_DELAY_EN_BIT];
            pattern_n_reg <= STATE_RESET[`ST_PATTERN_BIT];
            rate_n_reg <= STATE_RESET[`ST_RATE_BIT];
            edge_reg <= STATE_RESET[`ST_EDGE_BIT];
            pulse_n_reg <= STATE_RESET[`ST_PULSE_BIT];
            gain_reg <= `GAIN_TRIM_RESET;
            offset_reg <= `OFFSET_TRIM_RESET;
            coarse_reg <= `DELAY_COARSE_RESET;
            fine_reg <= `DELAY_FINE_RESET;
            spare_reg <= `SPARE_FIELD_RESET;
            pattern_reg <= PATTERN_RESET;
         end else if (frame.wr_pulse) begin
            case (frame.wr_addr)
               `OPERATING_STATE_ADDR: begin
                  demux_reg <= frame.wr_data[`ST_DEMUX_BIT];
                  delay_en_n_reg <= frame.wr_data[`ST_DELAY_EN_BIT];
                  pattern_n_reg <= frame.wr_data[`ST_PATTERN_BIT];
                  rate_n_reg <= frame.wr_data[`ST_RATE_BIT];
                  edge_reg <= frame.wr_data[`ST_EDGE_BIT];
                  pulse_n_reg <= frame.wr_data[`ST_PULSE_BIT];
               end
               `GAIN_TRIM_ADDR: begin
                  gain_reg <= frame.wr_data[9:0];
               end
               `OFFSET_TRIM_ADDR: begin
                  offset_reg <= frame.wr_data[9:0];
               end
               `APERTURE_DELAY_TRIM_ADDR: begin
                  coarse_reg <= frame.wr_data[9:8];
                  fine_reg <= frame.wr_data[7:0];
               end
               `SPARE_RESERVED_ADDR: begin
                  spare_reg <= frame.wr_data[4:0];
               end
               `PATTERN_SELECT_ADDR: begin
                  pattern_reg <= frame.wr_data[PATTERN_W-1:0];
               end
               default: begin
                  // reserved address: frame ends, nothing stored
                  spare_reg <= spare_reg;
               end
            endcase
         end
      end
   end

   // alignment pulse synchroniser
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         align_s1_reg <= 1'b0;
         align_s2_reg <= 1'b0;
         align_d_reg <= 1'b0;
      end else if (ce_in) begin
         align_s1_reg <= align_pulse_in;
         align_s2_reg <= align_s1_reg;
         align_d_reg <= align_s2_reg;
      end
   end

   // active edge as chosen by the edge select bit
   assign align_rise = align_s2_reg & ~align_d_reg;
   assign align_fall = ~align_s2_reg & align_d_reg;
   assign align_hit = edge_reg ? align_fall : align_rise;

   // trigger mode forwards the pulse and blocks realignment
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         parity_reg <= 2'h0;
         realign_reg <= 1'b0;
      end else if (ce_in) begin
         parity_reg <= {2{~pulse_n_reg & align_s2_reg}};
         realign_reg <= pulse_n_reg & align_hit;
      end
   end

   // free-running phase, cleared only by realignment; the test mode bit
   // is deliberately kept out so pattern switching never slips phase
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_reg <= 2'h0;
      end else if (ce_in) begin
         if (pulse_n_reg & align_hit) begin
            phase_reg <= 2'h0;
         end else begin
            phase_reg <= 2'(phase_reg + 2'h1);
         end
      end
   end

   // outputs straight from the field flops
   assign demux_ratio_select_out = demux_reg;
   assign delay_trim_enable_n_out = delay_en_n_reg;
   assign pattern_mode_n_out = pattern_n_reg;
   assign fast_output_rate_n_out = rate_n_reg;
   assign alignment_edge_select_out = edge_reg;
   assign pulse_mode_select_n_out = pulse_n_reg;
   assign amplitude_trim_out = gain_reg;
   assign offset_trim_out = offset_reg;
   assign delay_coarse_out = coarse_reg;
   assign delay_fine_out = fine_reg;
   assign spare_field_out = spare_reg;
   assign pattern_type_out = pattern_reg;
   assign parity_output_pair_out = parity_reg;
   assign realign_out = realign_reg;
   assign sync_phase_out = phase_reg;

   // checking helpers: run of low samples and a shadow shifter
   logic [4:0] low_run_reg;
   logic [15:0] shadow_reg;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_run_reg <= 5'h00;
         shadow_reg <= 16'h0000;
      end else if (ce_in && link_tick) begin
         shadow_reg <= {shadow_reg[14:0], mosi_d_reg};
         if (sld_d_reg) begin
            low_run_reg <= 5'h00;
         end else if (low_run_reg != 5'h1f) begin
            low_run_reg <= 5'(low_run_reg + 5'h01);
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_write(logic [3:0] a);
      frame.wr_pulse && frame.wr_addr == a && !defaults_load && ce_in;
   endsequence

   sequence s_sync_edge;
      ce_in && pulse_n_reg && align_hit;
   endsequence

   a_write_after_16: assert property (
      frame.wr_pulse |-> low_run_reg == 5'h10)
      else $error("write without exactly sixteen low samples");

   a_abort_no_write: assert property (
      (ce_in && link_tick && sld_d_reg) |=> !frame.wr_pulse)
      else $error("write after a high strobe sample");

   a_msb_first_order: assert property (
      frame.wr_pulse |-> {frame.wr_addr, frame.wr_data} == shadow_reg)
      else $error("frame bits not taken msb first");

   a_gain_store: assert property (
      s_write(`GAIN_TRIM_ADDR) |=> gain_reg == $past(frame.wr_data[9:0]))
      else $error("gain trim not stored");

   a_state_fields: assert property (
      s_write(`OPERATING_STATE_ADDR) |=>
      {pulse_n_reg, edge_reg, rate_n_reg} == $past(frame.wr_data[8:6]) &&
      {pattern_n_reg, delay_en_n_reg, demux_reg} ==
      $past(frame.wr_data[2:0]))
      else $error("state fields not stored");

   a_delay_split: assert property (
      s_write(`APERTURE_DELAY_TRIM_ADDR) |=>
      {coarse_reg, fine_reg} == $past(frame.wr_data[9:0]))
      else $error("delay trim fields misplaced");

   a_reserved_quiet: assert property (
      (frame.wr_pulse && frame.wr_addr > `PATTERN_SELECT_ADDR &&
      !defaults_load) |=> $stable(gain_reg) && $stable(offset_reg) &&
      $stable(spare_reg) && $stable(pattern_reg) && $stable(pulse_n_reg))
      else $error("reserved address changed a register");

   a_defaults_load: assert property (
      (ce_in && defaults_load) |=> gain_reg == `GAIN_TRIM_RESET &&
      offset_reg == `OFFSET_TRIM_RESET && coarse_reg == `DELAY_COARSE_RESET
      && spare_reg == `SPARE_FIELD_RESET && pattern_reg == PATTERN_RESET &&
      demux_reg && pulse_n_reg)
      else $error("defaults not loaded");

   a_trigger_forward: assert property (
      (ce_in && !pulse_n_reg) |=> !realign_reg &&
      parity_reg == {2{$past(align_s2_reg)}})
      else $error("trigger mode pulse path wrong");

   a_realign_phase: assert property (
      s_sync_edge |=> realign_reg && phase_reg == 2'h0 ##1
      (!ce_in || phase_reg == 2'h1 || realign_reg))
      else $error("realignment did not reset phase");

   a_pattern_steady: assert property (
      (ce_in && $changed(pattern_n_reg) && !$past(realign_reg) &&
      !(pulse_n_reg && align_hit)) |=>
      phase_reg == 2'($past(phase_reg) + 2'h1))
      else $error("test mode change disturbed phase");
endmodule
`default_nettype wire

// File: bench/cfg_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the controller that loads the configuration port
module cfg_controller_model (
   // frame request from the bench
   input wire logic go_in,
   input wire logic [15:0] word_in,
   input wire logic [5:0] low_count_in,
   input wire logic park_low_in,
   // link pins
   output logic sck_out,
   output wire logic sld_n_out,
   output logic mosi_out,
   output logic busy_out
);
   logic sld_frame;
   int i;

   // park holds the strobe low with the clock still, for the default load
   assign sld_n_out = sld_frame & ~park_low_in;

   // link idles with the strobe high and the clock standing still
   initial begin
      sck_out = 1'b0;
      sld_frame = 1'b1;
      mosi_out = 1'b0;
      busy_out = 1'b0;
   end

   // one frame; data moves on the low half, so 100 ns settles around rise
   always @(posedge go_in) begin
      busy_out = 1'b1;
      for (i = 0; i < int'(low_count_in); i++) begin
         sld_frame = 1'b0;
         // past 16 bits the data is junk that flips every sample
         mosi_out = (i < 16) ? word_in[15 - i] : ~mosi_out;
         #100 sck_out = 1'b1;
         #100 sck_out = 1'b0;
      end
      // a single high sample ends it; data released, so it flips
      sld_frame = 1'b1;
      mosi_out = ~mosi_out;
      #100 sck_out = 1'b1;
      #100 sck_out = 1'b0;
      busy_out = 1'b0;
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_regs.svh"
// one compare: counted, and a miss is reported and counted
`define CHECK(what, exp, got) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
   end \
end
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic cfg_reset_n = 1'b1;
   logic align = 1'b0;
   logic go = 1'b0;
   logic park = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [5:0] low_count = 6'd16;
   logic sck, sld_n, mosi, busy;
   logic demux, trim_en_n, pat_n, rate_n, edge_sel, pulse_n, realign;
   logic [9:0] gain, offs;
   logic [1:0] coarse, parity, phase;
   logic [7:0] fine;
   logic [4:0] spare;
   logic [3:0] pat;
   logic [11:0] exp_state, exp_pat;
   logic [9:0] exp_gain, exp_off, exp_delay;
   logic [4:0] exp_spare;
   int n_errors = 0;
   int checks = 0;
   int n_realign = 0;
   int a;

   // 40 MHz system clock
   always #12.5 clk = ~clk;

   config_serial_port config_serial_port_i (
      .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
      .sck_in(sck), .sld_n_in(sld_n), .mosi_in(mosi),
      .cfg_reset_n_in(cfg_reset_n), .align_pulse_in(align),
      .demux_ratio_select_out(demux), .delay_trim_enable_n_out(trim_en_n),
      .pattern_mode_n_out(pat_n), .fast_output_rate_n_out(rate_n),
      .alignment_edge_select_out(edge_sel),
      .pulse_mode_select_n_out(pulse_n),
      .amplitude_trim_out(gain), .offset_trim_out(offs),
      .delay_coarse_out(coarse), .delay_fine_out(fine),
      .spare_field_out(spare), .pattern_type_out(pat),
      .parity_output_pair_out(parity), .realign_out(realign),
      .sync_phase_out(phase)
   );

   cfg_controller_model cfg_controller_model_i (
      .go_in(go), .word_in(word), .low_count_in(low_count),
      .park_low_in(park), .sck_out(sck), .sld_n_out(sld_n),
      .mosi_out(mosi), .busy_out(busy)
   );

   // realign is a one-cycle pulse, so counting pulses sees every edge
   always @(posedge clk)
      if (realign === 1'b1) n_realign++;

   task automatic print_verdict();
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // inputs always move the same 2 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic load_defaults();
      exp_state = `OPERATING_STATE_RESET;
      exp_gain = `GAIN_TRIM_RESET;
      exp_off = `OFFSET_TRIM_RESET;
      exp_delay = {`DELAY_COARSE_RESET, `DELAY_FINE_RESET};
      exp_spare = `SPARE_FIELD_RESET;
      exp_pat = `PATTERN_TYPE_RESET;
   endtask

   task automatic check_regs();
      `CHECK("demux", exp_state[`ST_DEMUX_BIT], demux)
      `CHECK("trim enable", exp_state[`ST_DELAY_EN_BIT], trim_en_n)
      `CHECK("pattern mode", exp_state[`ST_PATTERN_BIT], pat_n)
      `CHECK("rate", exp_state[`ST_RATE_BIT], rate_n)
      `CHECK("edge", exp_state[`ST_EDGE_BIT], edge_sel)
      `CHECK("pulse mode", exp_state[`ST_PULSE_BIT], pulse_n)
      `CHECK("gain", exp_gain, gain)
      `CHECK("offset", exp_off, offs)
      `CHECK("coarse", exp_delay[9:8], coarse)
      `CHECK("fine", exp_delay[7:0], fine)
      `CHECK("spare", exp_spare, spare)
      `CHECK("pattern", exp_pat[3:0], pat)
   endtask

   // one frame of n strobe-low samples; only 16 or more may write
   task automatic wr(input logic [3:0] ad, input logic [11:0] d,
         input logic [5:0] n);
      int k;
      word = {ad, d};
      low_count = n;
      go = 1'b1;
      step(1);
      go = 1'b0;
      for (k = 0; k < 400 && busy === 1'b1; k++)
         step(1);
      `CHECK("link idle", 1'b0, busy)
      if (busy !== 1'b0)
         print_verdict();
      // update lands a few clocks after the last tick; 8 is ample margin
      step(8);
      if (n >= 6'd16) begin
         case (ad)
            `OPERATING_STATE_ADDR: exp_state = d;
            `GAIN_TRIM_ADDR: exp_gain = d[9:0];
            `OFFSET_TRIM_ADDR: exp_off = d[9:0];
            `APERTURE_DELAY_TRIM_ADDR: exp_delay = d[9:0];
            `SPARE_RESERVED_ADDR: exp_spare = d[4:0];
            `PATTERN_SELECT_ADDR: exp_pat = d;
            default: ;
         endcase
      end
      check_regs();
   endtask

   // alignment pulse: realign counts after the high and low phases
   task automatic pulse(input int up_n, input int dn_n,
         input logic [1:0] par);
      int c0;
      c0 = n_realign;
      align = 1'b1;
      step(10);
      `CHECK("parity high", par, parity)
      `CHECK("realign rise", up_n, n_realign - c0)
      // realign lands 3 edges after the pin moves, 7 more edges follow
      if (up_n > 0)
         `CHECK("phase after rise", 2'h3, phase)
      align = 1'b0;
      step(10);
      `CHECK("realign fall", up_n + dn_n, n_realign - c0)
      `CHECK("parity low", 2'b00, parity)
      if (dn_n > 0)
         `CHECK("phase after fall", 2'h3, phase)
   endtask

   initial begin
      load_defaults();
      step(20);
      rst_n = 1'b1;
      step(5);
      check_regs();
      wr(`OPERATING_STATE_ADDR, 12'he38, 6'd16);
      wr(`OPERATING_STATE_ADDR, 12'hff9, 6'd16);
      wr(`GAIN_TRIM_ADDR, 12'hfff, 6'd16);
      wr(`GAIN_TRIM_ADDR, 12'h000, 6'd16);
      wr(`OFFSET_TRIM_ADDR, 12'hc55, 6'd16);
      wr(`APERTURE_DELAY_TRIM_ADDR, 12'h3a5, 6'd16);
      wr(`SPARE_RESERVED_ADDR, 12'hfea, 6'd16);
      wr(`PATTERN_SELECT_ADDR, 12'hff6, 6'd16);
      // reserved addresses take the whole frame and store nothing
      for (a = 6; a < 16; a++)
         wr(a[3:0], 12'h000, 6'd16);
      wr(`GAIN_TRIM_ADDR, 12'h123, 6'd15);
      wr(`GAIN_TRIM_ADDR, 12'h2cd, 6'd20);
      // port reset alone does nothing; with the strobe low it loads defaults
      cfg_reset_n = 1'b0;
      step(10);
      check_regs();
      park = 1'b1;
      step(10);
      load_defaults();
      check_regs();
      cfg_reset_n = 1'b1;
      step(4);
      park = 1'b0;
      step(4);
      // sync mode: falling edge by default, then rising
      pulse(0, 1, 2'b00);
      // enable low freezes everything: no edge seen, phase holds
      ce = 1'b0;
      a = phase;
      pulse(0, 0, 2'b00);
      step(1);
      `CHECK("frozen phase", a, phase)
      ce = 1'b1;
      step(4);
      wr(`OPERATING_STATE_ADDR, 12'hf7f, 6'd16);
      pulse(1, 0, 2'b00);
      // turning the test pattern on must not realign anything
      a = n_realign;
      wr(`OPERATING_STATE_ADDR, 12'hf7b, 6'd16);
      `CHECK("realign on mode change", a, n_realign)
      wr(`OPERATING_STATE_ADDR, 12'heff, 6'd16);
      pulse(0, 0, 2'b11);
      print_verdict();
   end
endmodule
`default_nettype wire
